// File: hdl/smp_message_parser.sv
// character-level program message parser with keyword tree tracking
`timescale 1ns/100ps
`include "smp_cfg.svh"
module smp_message_parser
	import smp_pkg::*;
(
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic [7:0] char_i,
	input wire logic char_eol_i,
	input wire logic char_valid_i,
	output logic char_ready_o,
	input wire logic sink_ready_i,
	output logic unit_valid_o,
	output logic unit_error_o,
	output logic unit_query_o,
	output logic unit_common_o,
	output logic unit_data_o,
	output logic [2:0] unit_depth_o,
	output logic [19:0] unit_path_o,
	output logic data_valid_o,
	output logic [7:0] data_char_o,
	output logic err_push_o,
	output logic [2:0] err_code_o,
	output logic cmd_error_o,
	output logic msg_end_o
);
	localparam int NKW = `SMP_KW_COUNT;
	// keyword table, entry g has id g+1
	localparam logic [95:0] KW_TXT [NKW] = '{
		"ABORT", "CALIBRATE", "DISPLAY", "INITIATE", "LIST", "MEASURE",
		"OUTPUT", "SOURCE", "STATUS", "SYSTEM", "TRIGGER", "VOLTAGE",
		"CURRENT", "FUNCTION", "LEVEL", "IMMEDIATE", "OPERATION", "PRESET",
		"QUESTIONABLE", "CONDITION", "ENABLE", "EVENT", "MODE", "ERROR"};
	localparam logic [NKW-1:0] KW_ROOT = `SMP_KW_ROOT_MASK;
	localparam logic [NKW-1:0] KW_SUB = `SMP_KW_SUB_MASK;

	// letters in a long form
	function automatic int kw_long(input logic [95:0] t);
		int n;
		n = 0;
		for (int i = 0; i < 12; i++)
			if (t[i*8 +: 8] != 8'h00)
				n = i + 1;
		return n;
	endfunction

	// letters in the short form
	function automatic int kw_short(input logic [95:0] t);
		int n;
		logic [7:0] c4;
		n = kw_long(t);
		c4 = 8'h00;
		if (n <= 4)
			return n;
		c4 = t[(n-4)*8 +: 8];
		if (c4 inside {8'h41, 8'h45, 8'h49, 8'h4f, 8'h55})
			return 3;
		return 4;
	endfunction

	smp_fifo_if #(.WIDTH(`SMP_FIFO_WIDTH)) fq ();

	smp_state_t st_r;
	smp_state_t st_nxt;
	smp_err_t ecode;
	smp_kw_id_t hit_id;
	logic [7:0] ch;
	logic [7:0] up_ch;
	logic eolf;
	logic take;
	logic ignore;
	logic step;
	logic is_term;
	logic is_end;
	logic is_letter;
	logic at_root;
	logic push_bad;
	logic [NKW-1:0] kw_hit;
	logic [95:0] kw_buf_r;
	logic [3:0] kw_len_r;
	logic [2:0] depth_r;
	logic [2:0] depth_new;
	logic [19:0] path_r;
	logic [19:0] path_new;
	logic colon_r;
	logic qry_r;
	logic hasd_r;
	logic com_r;
	logic err_seen_r;
	logic do_app;
	logic do_push;
	logic do_fin;
	logic do_term;
	logic do_err;
	logic do_data;
	logic do_qry;
	logic do_root;
	logic do_com;
	logic do_hasd;
	logic bad;
	logic unit_valid_r;
	logic unit_error_r;
	logic unit_query_r;
	logic unit_common_r;
	logic unit_data_r;
	logic [2:0] unit_depth_r;
	logic [19:0] unit_path_r;
	logic data_valid_r;
	logic [7:0] data_char_r;
	logic err_push_r;
	logic [2:0] err_code_r;
	logic cmd_error_r;
	logic msg_end_r;

	// queue between the link side and the parser
	smp_fifo u_fifo (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.ce_i(ce_i),
		.q_if(fq)
	);
	assign fq.wr_data = {char_eol_i, char_i};
	assign fq.wr_valid = char_valid_i;
	assign fq.rd_ready = sink_ready_i;
	assign char_ready_o = fq.wr_ready;

	// character classification
	assign ch = fq.rd_data[7:0];
	assign eolf = fq.rd_data[8];
	assign take = ce_i & fq.rd_valid & sink_ready_i;
	assign ignore = (ch == `SMP_CH_CR) & ~eolf; // carriage return is dropped
	assign step = take & ~ignore;
	assign is_term = (ch == `SMP_CH_NL) | eolf;
	assign is_end = is_term | (ch == `SMP_CH_SEMI);
	assign up_ch = (ch >= `SMP_CH_LOW_A && ch <= `SMP_CH_LOW_Z) ? (ch & `SMP_CASE_MASK) : ch;
	assign is_letter = (up_ch >= `SMP_CH_UP_A) && (up_ch <= `SMP_CH_UP_Z);
	assign at_root = (depth_r == 3'h0);

	// one matcher per keyword entry
	for (genvar g = 0; g < NKW; g++)
	begin : g_kw
		localparam int LL = kw_long(KW_TXT[g]);
		localparam int SL = kw_short(KW_TXT[g]);
		localparam logic [95:0] SHORT_TXT = KW_TXT[g] >> ((LL - SL) * 8);
		localparam logic [3:0] LL4 = 4'(LL);
		localparam logic [3:0] SL4 = 4'(SL);
		logic form_ok;
		assign form_ok = (kw_len_r == LL4 && kw_buf_r == KW_TXT[g]) ||
			(kw_len_r == SL4 && kw_buf_r == SHORT_TXT);
		assign kw_hit[g] = form_ok && (at_root ? KW_ROOT[g] : KW_SUB[g]);
	end

	// hit encoder and tree insertion of the matched keyword
	always_comb
	begin
		hit_id = '0;
		for (int g = 0; g < NKW; g++)
			if (kw_hit[g])
				hit_id = 5'(g + 1);
		push_bad = (kw_hit == '0) || (depth_r == `SMP_TREE_MAX);
		path_new = path_r;
		// slots above the new keyword clear, so a path holds only its own keywords
		for (int i = 0; i < 4; i++)
			if (do_push && depth_r == 3'(i))
				path_new[i*5 +: 5] = hit_id;
			else if (do_push && depth_r < 3'(i))
				path_new[i*5 +: 5] = 5'h00;
		depth_new = depth_r + {2'b00, do_push};
	end

	// next state and per-character actions
	always_comb
	begin
		st_nxt = st_r;
		ecode = ERR_NONE;
		do_app = 1'b0;
		do_push = 1'b0;
		do_fin = 1'b0;
		do_term = 1'b0;
		do_err = 1'b0;
		do_data = 1'b0;
		do_qry = 1'b0;
		do_root = 1'b0;
		do_com = 1'b0;
		do_hasd = 1'b0;
		if (step)
		begin
			case (st_r)
				ST_START:
					if (is_term)
					begin
						do_term = 1'b1;
						if (colon_r)
						begin
							do_err = 1'b1;
							ecode = ERR_SEPARATOR;
						end
					end
					else if (ch == `SMP_CH_COLON && !colon_r)
						do_root = 1'b1;
					else if (ch == `SMP_CH_STAR && !colon_r)
					begin
						do_com = 1'b1;
						st_nxt = ST_COMMON;
					end
					else if (is_letter)
					begin
						do_app = 1'b1;
						st_nxt = ST_KEY;
					end
					else if (!(ch == `SMP_CH_SPACE && !colon_r))
					begin
						do_err = 1'b1;
						ecode = ERR_SEPARATOR;
					end
				ST_KEY:
					if (is_end)
					begin
						do_push = 1'b1; // end-of-line flag beats the letter it rides on
						do_fin = 1'b1;
						do_term = is_term;
						st_nxt = ST_START;
					end
					else if (is_letter)
					begin
						do_app = 1'b1;
						if (kw_len_r == `SMP_KW_MAX)
						begin
							do_err = 1'b1;
							ecode = ERR_LENGTH;
						end
					end
					else if (ch == `SMP_CH_COLON)
						do_push = 1'b1;
					else if (ch == `SMP_CH_QUERY)
					begin
						do_push = 1'b1;
						do_qry = 1'b1;
						st_nxt = ST_QRY;
					end
					else if (ch == `SMP_CH_SPACE)
					begin
						do_push = 1'b1;
						st_nxt = ST_SEP;
					end
					else
					begin
						do_err = 1'b1;
						ecode = ERR_DATA;
					end
				ST_QRY:
					if (is_end)
					begin
						do_fin = 1'b1;
						do_term = is_term;
						st_nxt = ST_START;
					end
					else if (ch == `SMP_CH_SPACE)
						st_nxt = ST_SEP;
					else
					begin
						do_err = 1'b1;
						ecode = ERR_DATA;
					end
				ST_SEP, ST_DATA, ST_COMMON, ST_SKIP:
					if (is_end)
					begin
						do_fin = 1'b1;
						do_term = is_term;
						st_nxt = ST_START;
					end
					else if (st_r == ST_SEP && ch == `SMP_CH_SPACE)
						st_nxt = ST_SEP;
					else if (st_r != ST_SKIP)
					begin
						do_data = 1'b1;
						do_hasd = (st_r != ST_COMMON);
						st_nxt = (st_r == ST_COMMON) ? ST_COMMON : ST_DATA;
					end
				default:
					st_nxt = ST_START;
			endcase
		end
		// error discards the rest of the unit
		bad = do_err | (do_push & push_bad);
		if (bad)
		begin
			if (!do_err)
				ecode = (depth_r == `SMP_TREE_MAX) ? ERR_DEPTH : ERR_KEYWORD;
			do_app = 1'b0;
			do_push = 1'b0;
			do_data = 1'b0;
			do_qry = 1'b0;
			do_fin = is_end;
			do_term = is_term;
			st_nxt = is_end ? ST_START : ST_SKIP;
		end
	end

	// state register
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
			st_r <= ST_START;
		else if (ce_i)
			st_r <= st_nxt;
	end

	// keyword collection buffer, upper case, last letter in the low byte
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			kw_buf_r <= '0;
			kw_len_r <= 4'h0;
		end
		else if (step)
		begin
			if (do_app)
			begin
				kw_buf_r <= {kw_buf_r[87:0], up_ch};
				kw_len_r <= kw_len_r + 4'h1;
			end
			else if (do_push || st_nxt != ST_KEY)
			begin
				kw_buf_r <= '0;
				kw_len_r <= 4'h0;
			end
		end
	end

	// tree position, held as the base level between units
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			depth_r <= 3'h0;
			path_r <= '0;
		end
		else if (step)
		begin
			path_r <= path_new;
			if (do_term || do_root || (do_fin && (bad || err_seen_r)))
				depth_r <= 3'h0;
			else if (do_fin && !com_r)
				depth_r <= depth_new - 3'h1;
			else if (do_push)
				depth_r <= depth_new;
		end
	end

	// per-unit flags
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			colon_r <= 1'b0;
			qry_r <= 1'b0;
			hasd_r <= 1'b0;
			com_r <= 1'b0;
			err_seen_r <= 1'b0;
		end
		else if (step)
		begin
			colon_r <= do_root & ~bad;
			qry_r <= do_fin ? 1'b0 : (qry_r | do_qry);
			hasd_r <= do_fin ? 1'b0 : (hasd_r | do_hasd);
			com_r <= do_fin ? 1'b0 : (com_r | do_com);
			err_seen_r <= do_fin ? 1'b0 : (err_seen_r | bad);
		end
	end

	// unit, data and error outputs
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			unit_valid_r <= 1'b0;
			unit_error_r <= 1'b0;
			unit_query_r <= 1'b0;
			unit_common_r <= 1'b0;
			unit_data_r <= 1'b0;
			unit_depth_r <= 3'h0;
			unit_path_r <= '0;
			data_valid_r <= 1'b0;
			data_char_r <= 8'h00;
			err_push_r <= 1'b0;
			err_code_r <= 3'h0;
			msg_end_r <= 1'b0;
		end
		else if (ce_i)
		begin
			unit_valid_r <= do_fin;
			data_valid_r <= do_data;
			err_push_r <= bad;
			msg_end_r <= do_term;
			if (do_fin)
			begin
				unit_error_r <= bad | err_seen_r;
				unit_query_r <= qry_r;
				unit_common_r <= com_r;
				unit_data_r <= hasd_r;
				unit_depth_r <= depth_new;
				unit_path_r <= path_new;
			end
			if (do_data)
				data_char_r <= ch;
			if (bad)
				err_code_r <= ecode;
		end
	end

	// status bit 3, error set wins over a clean unit
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
			cmd_error_r <= 1'b0;
		else if (ce_i)
		begin
			if (bad)
				cmd_error_r <= 1'b1;
			else if (do_fin && !err_seen_r)
				cmd_error_r <= 1'b0;
		end
	end

	assign unit_valid_o = unit_valid_r;
	assign unit_error_o = unit_error_r;
	assign unit_query_o = unit_query_r;
	assign unit_common_o = unit_common_r;
	assign unit_data_o = unit_data_r;
	assign unit_depth_o = unit_depth_r;
	assign unit_path_o = unit_path_r;
	assign data_valid_o = data_valid_r;
	assign data_char_o = data_char_r;
	assign err_push_o = err_push_r;
	assign err_code_o = err_code_r;
	assign cmd_error_o = cmd_error_r;
	assign msg_end_o = msg_end_r;

	// checks
	default clocking chk_cb @(posedge clock_i);
	endclocking
	default disable iff (!resetn_i);

	sequence s_query_end;
		step && st_r == ST_QRY && is_end;
	endsequence
	sequence s_data_start;
		step && st_r == ST_SEP && !is_end && ch != `SMP_CH_SPACE;
	endsequence
	sequence s_sep_ok;
		step && st_r == ST_KEY && ch == `SMP_CH_COLON && !push_bad;
	endsequence

	chk_nl_terminates: assert property (take && ch == `SMP_CH_NL |=> msg_end_o)
		else $error("newline did not end the message");
	chk_eol_terminates: assert property (take && eolf |=> msg_end_o)
		else $error("end-of-line flag did not end the message");
	chk_term_root: assert property (msg_end_o |-> depth_r == 3'h0)
		else $error("tree not at root after terminator");
	chk_sep_deeper: assert property (s_sep_ok |=> depth_r == $past(depth_r) + 3'h1)
		else $error("separator did not descend one level");
	chk_root_colon: assert property (step && st_r == ST_START && ch == `SMP_CH_COLON
		&& !colon_r |=> depth_r == 3'h0 && colon_r)
		else $error("root specifier did not return to root");
	chk_sibling_base: assert property (unit_valid_o && !unit_error_o && !unit_common_o
		&& !msg_end_o |-> depth_r == unit_depth_o - 3'h1)
		else $error("next unit base is not the parent level");
	chk_query_unit: assert property (s_query_end |=> unit_valid_o && unit_query_o)
		else $error("query unit not flagged");
	chk_data_space: assert property (s_data_start |=> data_valid_o && st_r == ST_DATA)
		else $error("data after space not passed");
	chk_common_unit: assert property (step && st_r == ST_START && ch == `SMP_CH_STAR
		&& !colon_r |=> st_r == ST_COMMON)
		else $error("asterisk did not open a common command");
	chk_error_queued: assert property (bad |=> err_push_o && cmd_error_o)
		else $error("error not queued");
	chk_valid_clears: assert property (unit_valid_o && !unit_error_o |-> !cmd_error_o)
		else $error("clean unit left status bit 3 set");
endmodule

// File: hdl/smp_cfg.svh
// character codes, limits and sizes for the message parser
`ifndef SMP_CFG_SVH
`define SMP_CFG_SVH
`define SMP_CH_NL 8'h0a
`define SMP_CH_CR 8'h0d
`define SMP_CH_SPACE 8'h20
`define SMP_CH_STAR 8'h2a
`define SMP_CH_COLON 8'h3a
`define SMP_CH_SEMI 8'h3b
`define SMP_CH_QUERY 8'h3f
`define SMP_CH_UP_A 8'h41
`define SMP_CH_UP_Z 8'h5a
`define SMP_CH_LOW_A 8'h61
`define SMP_CH_LOW_Z 8'h7a
`define SMP_CASE_MASK 8'hdf
`define SMP_FIFO_DEPTH 32
`define SMP_FIFO_WIDTH 9
`define SMP_KW_MAX 4'hc
`define SMP_TREE_MAX 3'h4
`define SMP_KW_COUNT 24
`define SMP_KW_ROOT_MASK 24'h003fff
`define SMP_KW_SUB_MASK 24'hfff800
`endif

// File: hdl/smp_pkg.sv
// types shared by the message parser and its input queue
package smp_pkg;
`include "smp_cfg.svh"
	// one-hot parser states
	typedef enum logic [6:0] {
		ST_START = 7'h01,
		ST_KEY = 7'h02,
		ST_QRY = 7'h04,
		ST_SEP = 7'h08,
		ST_DATA = 7'h10,
		ST_COMMON = 7'h20,
		ST_SKIP = 7'h40
	} smp_state_t;
	// codes of queued error entries
	typedef enum logic [2:0] {
		ERR_NONE = 3'h0,
		ERR_KEYWORD = 3'h1,
		ERR_SEPARATOR = 3'h2,
		ERR_DATA = 3'h3,
		ERR_DEPTH = 3'h4,
		ERR_LENGTH = 3'h5
	} smp_err_t;
	typedef logic [4:0] smp_kw_id_t;
endpackage

// File: hdl/smp_fifo_if.sv
// valid/ready carrier between the parser and its input queue
`timescale 1ns/100ps
interface smp_fifo_if #(parameter int WIDTH = 9);
	logic [WIDTH-1:0] wr_data;
	logic wr_valid;
	logic wr_ready;
	logic [WIDTH-1:0] rd_data;
	logic rd_valid;
	logic rd_ready;
	modport queue (input wr_data, wr_valid, rd_ready, output wr_ready, rd_data, rd_valid);
	modport user (output wr_data, wr_valid, rd_ready, input wr_ready, rd_data, rd_valid);
endinterface

// File: hdl/smp_fifo.sv
// character queue in front of the parser
`timescale 1ns/100ps
`include "smp_cfg.svh"
module smp_fifo
	import smp_pkg::*;
#(
	parameter int WIDTH = `SMP_FIFO_WIDTH,
	parameter int DEPTH = `SMP_FIFO_DEPTH
)
(
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	smp_fifo_if.queue q_if
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wptr_r;
	logic [AW-1:0] rptr_r;
	logic [AW:0] count_r;
	logic [AW:0] count_nxt;
	logic space_r;
	logic push;
	logic pop;

	// handshakes, frozen while the clock enable is low
	assign push = ce_i & q_if.wr_valid & space_r;
	assign pop = ce_i & q_if.rd_valid & q_if.rd_ready;
	assign q_if.rd_valid = (count_r != '0);
	assign q_if.rd_data = mem_r[rptr_r];
	assign q_if.wr_ready = space_r;

	// occupancy after this cycle
	always_comb
	begin
		count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	// storage, no reset needed
	always_ff @(posedge clock_i)
	begin
		if (push)
			mem_r[wptr_r] <= q_if.wr_data;
	end

	// pointers wrap naturally, depth is a power of two
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			wptr_r <= '0;
			rptr_r <= '0;
			count_r <= '0;
			space_r <= 1'b1;
		end
		else
		begin
			if (push)
				wptr_r <= wptr_r + 1'b1;
			if (pop)
				rptr_r <= rptr_r + 1'b1;
			count_r <= count_nxt;
			space_r <= (count_nxt != FULL_COUNT); // registered not-full flag
		end
	end
endmodule

// File: dv/smp_host_model.sv
// remote controller model: sends program messages as a character stream
`timescale 1ns/100ps
module smp_host_model
(
	input wire logic clock_i,
	input wire logic ce_i,
	input wire logic char_ready_i,
	output logic [7:0] char_o,
	output logic char_eol_o,
	output logic char_valid_o,
	output logic timeout_o
);
	// idle line at time zero
	initial
	begin
		char_o = 8'h00;
		char_eol_o = 1'b0;
		char_valid_o = 1'b0;
		timeout_o = 1'b0;
	end
	// every character of the composed text goes out, none dropped or shortened
	// released line shows the inverse of the last character, never a stale copy
	task automatic send_msg(input string s, input bit eol_last, input int maxgap);
		int n;
		int g;
		for (int i = 0; i < s.len(); i++)
		begin
			g = $urandom_range(0, maxgap);
			if (g > 0 && char_valid_o === 1'b1)
			begin
				char_valid_o <= 1'b0;
				char_o <= ~char_o;
				char_eol_o <= 1'b0;
			end
			repeat (g) @(posedge clock_i);
			char_o <= s[i];
			char_eol_o <= eol_last && (i == s.len() - 1);
			char_valid_o <= 1'b1;
			n = 0;
			@(posedge clock_i);
			// hold the offer until an enabled edge sees ready
			while (!(char_ready_i === 1'b1 && ce_i === 1'b1) && n < 4000)
			begin
				n++;
				@(posedge clock_i);
			end
			if (n >= 4000)
				timeout_o <= 1'b1;
		end
		char_valid_o <= 1'b0;
		char_o <= ~s[s.len() - 1];
		char_eol_o <= 1'b0;
	endtask
endmodule

// File: dv/scpi_message_parser_tb_top.sv
// self-checking bench: controller model, unit monitor and message scenarios
`timescale 1ns/100ps
module scpi_message_parser_tb_top;
	logic clock_i, resetn_i, ce_i, sink_ready_i, hold_sink, char_eol_i, char_valid_i, tmo;
	logic [7:0] char_i, data_char_o;
	logic char_ready_o, unit_valid_o, unit_error_o, unit_query_o, unit_common_o, unit_data_o;
	logic data_valid_o, err_push_o, cmd_error_o, msg_end_o;
	logic [2:0] unit_depth_o, err_code_o;
	logic [19:0] unit_path_o;
	logic [26:0] units[$];
	logic [7:0] dq[$];
	logic [2:0] errq[$];
	int n_fail, num_checks, n_end;
	string kw[25] = '{"", "ABORT", "CALIBRATE", "DISPLAY", "INITIATE", "LIST", "MEASURE",
		"OUTPUT", "SOURCE", "STATUS", "SYSTEM", "TRIGGER", "VOLTAGE", "CURRENT", "FUNCTION",
		"LEVEL", "IMMEDIATE", "OPERATION", "PRESET", "QUESTIONABLE", "CONDITION", "ENABLE",
		"EVENT", "MODE", "ERROR"};

	smp_message_parser u_smp_message_parser (.clock_i(clock_i), .resetn_i(resetn_i),
		.ce_i(ce_i), .char_i(char_i), .char_eol_i(char_eol_i), .char_valid_i(char_valid_i),
		.char_ready_o(char_ready_o), .sink_ready_i(sink_ready_i), .unit_valid_o(unit_valid_o),
		.unit_error_o(unit_error_o), .unit_query_o(unit_query_o),
		.unit_common_o(unit_common_o), .unit_data_o(unit_data_o),
		.unit_depth_o(unit_depth_o), .unit_path_o(unit_path_o), .data_valid_o(data_valid_o),
		.data_char_o(data_char_o), .err_push_o(err_push_o), .err_code_o(err_code_o),
		.cmd_error_o(cmd_error_o), .msg_end_o(msg_end_o));
	smp_host_model u_smp_host_model (.clock_i(clock_i), .ce_i(ce_i),
		.char_ready_i(char_ready_o), .char_o(char_i), .char_eol_o(char_eol_i),
		.char_valid_o(char_valid_i), .timeout_o(tmo));

	initial
		clock_i = 1'b0;
	always #2.5 clock_i = ~clock_i;

	// random clock enable and sink stalls
	always @(posedge clock_i)
	begin
		ce_i <= ($urandom_range(0, 7) != 0);
		sink_ready_i <= hold_sink ? 1'b0 : ($urandom_range(0, 3) != 0);
	end

	// collect finished units, data characters, error entries and terminators
	always @(posedge clock_i)
		if (resetn_i === 1'b1 && ce_i === 1'b1)
		begin
			if (unit_valid_o === 1'b1)
				units.push_back({unit_error_o, unit_query_o, unit_common_o, unit_data_o,
					unit_depth_o, unit_path_o});
			if (data_valid_o === 1'b1)
				dq.push_back(data_char_o);
			if (err_push_o === 1'b1)
				errq.push_back(err_code_o);
			if (msg_end_o === 1'b1)
				n_end++;
		end

	function automatic logic [19:0] pth(int a, int b = 0, int c = 0);
		return {5'h00, c[4:0], b[4:0], a[4:0]};
	endfunction
	function automatic logic [26:0] uv(bit q, bit d, int dep, logic [19:0] p);
		return {1'b0, q, 1'b0, d, dep[2:0], p};
	endfunction
	// short form: whole word up to four letters, else three or four by the fourth letter
	function automatic string sform(string l);
		if (l.len() <= 4)
			return l;
		if (l[3] inside {"A", "E", "I", "O", "U"})
			return l.substr(0, 2);
		return l.substr(0, 3);
	endfunction
	// random letter case per character
	function automatic string mix(string s);
		for (int i = 0; i < s.len(); i++)
			if ($urandom_range(0, 1))
				s[i] = s[i] | 8'h20;
		return s;
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic clr();
		units.delete();
		dq.delete();
		errq.delete();
	endtask
	// bounded wait for the terminator pulse; a hang ends the run
	task automatic wait_end(input int e0);
		int n;
		for (n = 0; n < 4000 && n_end == e0; n++)
			@(posedge clock_i);
		if (n_end == e0 || tmo === 1'b1)
		begin
			n_fail++;
			$display("mismatch terminator expected pulse seen none");
			print_verdict();
		end
		repeat (2) @(posedge clock_i);
	endtask
	task automatic run(input string s, input bit eol);
		int e0;
		clr();
		e0 = n_end;
		u_smp_host_model.send_msg(s, eol, 2);
		wait_end(e0);
	endtask
	task automatic uexp(input int i, input logic [26:0] e);
		if (units.size() > i)
			check("unit", {5'h00, units[i]}, {5'h00, e});
		else
			check("unit count", units.size(), i + 1);
	endtask
	task automatic eexp(input logic [2:0] code);
		if (code != 3'h0)
			check("error code", (errq.size() > 0) ? errq[0] : 3'h0, code);
		check("error unit", (units.size() > 0) ? units[0][26] : 1'b0, 1);
		check("status bit", cmd_error_o, 1);
	endtask

	initial
	begin
		string m;
		int r;
		int c;
		int q;
		int b;
		int e0;
		n_fail = 0;
		num_checks = 0;
		n_end = 0;
		ce_i = 1'b1;
		sink_ready_i = 1'b1;
		hold_sink = 1'b0;
		resetn_i = 1'b0;
		r = $urandom(32'h44a9);
		repeat (2) @(posedge clock_i);
		check("ready in reset", char_ready_o, 1);
		check("unit in reset", {unit_valid_o, msg_end_o, cmd_error_o}, 0);
		repeat (3) @(posedge clock_i);
		resetn_i <= 1'b1;
		@(posedge clock_i);
		run("MEAS:VOLT?;CURR?\n", 0);
		uexp(0, uv(1, 0, 2, pth(6, 12)));
		uexp(1, uv(1, 0, 2, pth(6, 13)));
		run("curr?\n", 0);
		uexp(0, uv(1, 0, 1, pth(13)));
		run("MEAS:VOLT?;:CURR?\n", 0);
		uexp(1, uv(1, 0, 1, pth(13)));
		run(":STAT:OPER:COND?;ENAB 16\n", 0);
		uexp(0, uv(1, 0, 3, pth(9, 17, 20)));
		uexp(1, uv(0, 1, 3, pth(9, 17, 21)));
		check("data count", dq.size(), 2);
		if (dq.size() == 2)
			check("data", {dq[0], dq[1]}, 16'h3136);
		run("VOLT 5\n", 0);
		uexp(0, uv(0, 1, 1, pth(12)));
		run("*RST\n", 0);
		check("common", (units.size() > 0) ? units[0][24] : 1'b0, 1);
		run("TRIG:IMMX", 1);
		uexp(0, uv(0, 0, 2, pth(11, 16)));
		check("eol char as data", dq.size(), 0);
		run("MEASU\n", 0);
		eexp(3'h1);
		run("ABOR\015\n", 0);
		uexp(0, uv(0, 0, 1, pth(1)));
		check("status bit clear", cmd_error_o, 0);
		run("MEAS::VOLT\n", 0);
		eexp(3'h1);
		run("::STAT\n", 0);
		eexp(3'h2);
		run("STAT:OPER:COND:ENAB:EVEN\n", 0);
		eexp(3'h4);
		run("QUESTIONABLEX\n", 0);
		eexp(3'h5);
		run("LEV\n", 0);
		eexp(3'h1);
		run("MEAS:VOLT?5\n", 0);
		eexp(3'h3);
		// stall the parser until the queue refuses, then drain it
		clr();
		hold_sink = 1'b1;
		e0 = n_end;
		fork
			u_smp_host_model.send_msg(":STAT:PRES;:STAT:PRES;:STAT:PRES\n", 0, 0);
		join_none
		for (r = 0; r < 300 && char_ready_o !== 1'b0; r++)
			@(posedge clock_i);
		check("queue full", char_ready_o, 0);
		repeat (20) @(posedge clock_i);
		check("units while stalled", units.size(), 0);
		hold_sink = 1'b0;
		wait_end(e0);
		check("units after drain", units.size(), 3);
		// every root branch, random forms, case, child and query
		for (r = 1; r <= 14; r++)
		begin
			c = $urandom_range(12, 24);
			q = $urandom_range(0, 1);
			b = $urandom_range(0, 3);
			m = sform(kw[r]);
			if (b == 0 && kw[r].len() > m.len() + 1)
			begin
				run({mix(kw[r].substr(0, m.len())), "\n"}, 0);
				eexp(3'h1);
			end
			else
			begin
				m = b[0] ? kw[r] : m;
				m = {mix(m), ":", mix(b[1] ? kw[c] : sform(kw[c]))};
				if (q != 0)
					m = {m, "?"};
				run({m, "\n"}, 0);
				uexp(0, uv(q, 0, 2, pth(r, c)));
			end
		end
		print_verdict();
	end
endmodule
